// *** rtl/usb_device_end.sv ***
`timescale 1ns/1ps
`include "usb_dc_defines.svh"

// Summary of operation
// - Disabled event never reaches interrupt output
// - Enabling during ongoing event captures nothing
// - Status latches only already enabled events
// - Bus reset keeps interrupt enables
// - Enable register: 32 bits, two words
// - Software writes zero to bits 31-24
// - Bits 23-10 enable endpoints 14-1
// - Bit 9 control IN, 8 control OUT
// - Bit 6 enables short packet interrupt
// - Bit 5 enables pseudo frame interrupt
// - Bit 4 frame start, 3 transfer end
// - Bits 2-0: suspend, resume, bus reset
// - DMA configuration: 16 bits, one word
// - Bus reset clears only DMA run bit
// - Bit 15: end when counter hits zero
// - Bit 14: end on short OUT packet
// - Keep bit 14 clear for IN DMA
// - Bits 7-4 select DMA endpoint
// - Bit 3 starts, stops, shows DMA
// - Bits 1-0 select burst length
// - Run rising reloads remaining byte counter

// ----------------------------------------------------------------
// Device end: interrupt enable and DMA configuration registers
// ----------------------------------------------------------------
module usb_device_end (
  input wire logic clk_sys,
  input wire logic sys_rst,
  usb_dc_bus_if.device bus,
  input wire logic [15:0] ep_evt,
  input wire logic short_pkt_evt,
  input wire logic pseudo_sof_evt,
  input wire logic sof_evt,
  input wire logic suspend_evt,
  input wire logic resume_evt,
  input wire logic usb_bus_reset,
  input wire logic dma_byte_stb,
  input wire logic out_short_rx,
  output logic irq,
  output logic dma_run,
  output logic [3:0] dma_endpoint_select,
  output logic [1:0] dma_burst_length,
  output logic transfer_end_condition
);
  usb_dc_pkg::dev_state_s s; // Registered state
  usb_dc_pkg::dev_state_s n; // Next state
  logic [31:0] src;          // Raw event levels by status position
  logic [31:0] status;       // Latched interrupt status
  logic run_new;             // Run bit after a configuration write

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------

  // Each source sits at the position of its enable bit, so the enable
  // register gates it one to one
  always_comb begin
    src = '0;
    src[`EV_EP_MSB:`EV_EP_LSB] = ep_evt; // Endpoints and control pair
    src[`EV_SHORT] = short_pkt_evt;
    src[`EV_PSOF] = pseudo_sof_evt;
    src[`EV_SOF] = sof_evt;
    src[`EV_EOT] = s.xend;               // Own end-of-transfer pulse
    src[`EV_SUSP] = suspend_evt;
    src[`EV_RESM] = resume_evt;
    src[`EV_RST] = usb_bus_reset;
  end

  // Capture gate; the enable register is not an output mask
  event_latch u_latch (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .src(src),
    .en(s.ie),
    .clr(s.clr),
    .status(status)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Order inside: DMA counting, then bus access, then USB bus reset,
  // so a bus reset always gets the last word on the run bit
  always_comb begin
    n = s;
    n.xend = 1'b0;
    n.clr = '0;
    run_new = s.dcfg[`DCFG_RUN];

    // Remaining counter only moves while DMA runs
    if (dma_byte_stb && s.dcfg[`DCFG_RUN] && (s.remain != 16'h0000)) begin
      n.remain = s.remain - 16'h0001;
    end

    // End conditions: counter reaches zero, or short OUT packet
    if (s.dcfg[`DCFG_RUN] && !s.xend) begin
      if (s.dcfg[`DCFG_COUNT_TERMINATE_EN] && (s.remain == 16'h0000)) begin
        n.xend = 1'b1;
      end
      if (s.dcfg[`DCFG_SHORT_PACKET_MODE] && out_short_rx) begin
        n.xend = 1'b1;
      end
    end
    if (n.xend) begin
      n.dcfg[`DCFG_RUN] = 1'b0;            // Transfer over, DMA stops
    end

    // Bus access
    if (bus.wr_stb && bus.cmd_sel) begin
      // Command phase: restart word index and take a read snapshot
      n.cmd = bus.wdata[7:0];
      n.widx = 2'd0;
      case (bus.wdata[7:0])
        `CMD_IE_RD: begin
          n.shadow = s.ie;
        end
        `CMD_DCFG_RD: begin
          n.shadow = {16'h0000, s.dcfg};   // Run bit reads live state
        end
        `CMD_DCNT_RD: begin
          n.shadow = {16'h0000, s.remain}; // Bytes left in the transfer
        end
        `CMD_STAT_RD: begin
          n.shadow = status;
          n.clr = status;                  // Read clears what it returns
        end
        default: begin
          n.shadow = '0;                   // Unknown code reads zero
        end
      endcase
    end else if (bus.wr_stb) begin
      // Data phase of a write; extra words past the count are ignored
      if (s.widx < usb_dc_pkg::cmd_words(s.cmd)) begin
        n.widx = s.widx + 2'd1;
        case (s.cmd)
          `CMD_IE_WR: begin
            if (s.widx == 2'd0) begin
              n.lo = bus.wdata;            // Low word first
            end else begin
              // Whole value applies only with the high word; reserved
              // bits are dropped whatever software sends
              n.ie = {bus.wdata, s.lo} & `IE_MASK;
            end
          end
          `CMD_DCFG_WR: begin
            // Endpoint, burst and end modes are stored as written
            run_new = bus.wdata[`DCFG_RUN];
            n.dcfg = bus.wdata & `DCFG_MASK;
            // Zero forces an ongoing transfer to end
            if (run_new && !s.dcfg[`DCFG_RUN]) begin
              n.remain = s.dcount;         // Fresh start reloads
            end
          end
          `CMD_DCNT_WR: begin
            n.dcount = bus.wdata;
          end
          default: begin
            n.lo = s.lo;                   // No register behind this code
          end
        endcase
      end
    end else if (bus.rd_stb) begin
      // Data phase of a read: low word, then high word
      n.widx = s.widx + 2'd1;
      n.rdata = (s.widx == 2'd0) ? s.shadow[15:0] : s.shadow[31:16];
    end

    // USB bus reset stops DMA and touches nothing else
    if (usb_bus_reset) begin
      n.dcfg[`DCFG_RUN] = 1'b0;
    end

    // Interrupt follows the latched status, which already holds only
    // enabled events
    n.irq = |status;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Hardware reset clears every register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign irq = s.irq;
  assign dma_run = s.dcfg[`DCFG_RUN];
  assign dma_endpoint_select = s.dcfg[`DCFG_EP_MSB:`DCFG_EP_LSB];
  assign dma_burst_length = s.dcfg[`DCFG_BURST_MSB:0];
  assign transfer_end_condition = s.xend;
  assign bus.rdata = s.rdata;
endmodule // usb_device_end

// *** common/usb_dc_defines.svh ***
`ifndef USB_DC_DEFINES_SVH
`define USB_DC_DEFINES_SVH

// ----------------------------------------------------------------
// Command codes on the shared parallel bus
// ----------------------------------------------------------------
`define CMD_IE_WR 8'hc2
`define CMD_IE_RD 8'hc3
`define CMD_DCFG_WR 8'hf0
`define CMD_DCFG_RD 8'hf1
`define CMD_DCNT_WR 8'hf2
`define CMD_DCNT_RD 8'hf3
`define CMD_STAT_RD 8'hc1

// ----------------------------------------------------------------
// Writable bit masks; reserved bits store and read as zero
// ----------------------------------------------------------------
`define IE_MASK 32'h00ff_ff7f
`define DCFG_MASK 16'hc0fb

// ----------------------------------------------------------------
// Field positions of the DMA configuration register
// ----------------------------------------------------------------
`define DCFG_COUNT_TERMINATE_EN 15
`define DCFG_SHORT_PACKET_MODE 14
`define DCFG_EP_LSB 4
`define DCFG_EP_MSB 7
`define DCFG_RUN 3
`define DCFG_BURST_MSB 1

// ----------------------------------------------------------------
// Event positions, shared by enable and status registers
// ----------------------------------------------------------------
`define EV_EP_LSB 8
`define EV_EP_MSB 23
`define EV_SHORT 6
`define EV_PSOF 5
`define EV_SOF 4
`define EV_EOT 3
`define EV_SUSP 2
`define EV_RESM 1
`define EV_RST 0

// ----------------------------------------------------------------
// Host controller register offsets on AHB-Lite
// ----------------------------------------------------------------
`define H_CTRL 8'h00
`define H_WDATA 8'h04
`define H_RDATA 8'h08
`define H_STAT 8'h0c

`endif

// *** common/usb_dc_pkg.sv ***
`include "usb_dc_defines.svh"

package usb_dc_pkg;

  // Number of 16-bit data words that follow a command code
  function automatic logic [1:0] cmd_words(input logic [7:0] code);
    case (code)
      `CMD_IE_WR, `CMD_IE_RD, `CMD_STAT_RD: cmd_words = 2'd2;
      `CMD_DCFG_WR, `CMD_DCFG_RD, `CMD_DCNT_WR, `CMD_DCNT_RD: cmd_words = 2'd1;
      default: cmd_words = 2'd0;
    endcase
  endfunction

  // Device end state
  typedef struct packed {
    logic [7:0] cmd;     // Last command code
    logic [1:0] widx;    // Data word index after the command
    logic [15:0] lo;     // Low word held until the high word comes
    logic [31:0] ie;     // Interrupt enable register
    logic [15:0] dcfg;   // DMA configuration register
    logic [15:0] dcount; // Programmed DMA byte count
    logic [15:0] remain; // Remaining byte counter
    logic [31:0] shadow; // Read snapshot of the addressed register
    logic [31:0] clr;    // Status bits cleared this cycle
    logic [15:0] rdata;  // Read word on the bus
    logic irq;           // Interrupt output
    logic xend;          // End-of-transfer pulse
  } dev_state_s;

  // Event latch state
  typedef struct packed {
    logic [31:0] prev;   // Source levels of the last cycle
    logic [31:0] status; // Latched events
  } evt_state_s;

  // Host sequencer states
  typedef enum logic [1:0] {H_IDLE, H_CMD, H_DATA, H_RCAP} host_st_e;

  // Host end state
  typedef struct packed {
    host_st_e st;
    logic [7:0] cmd;     // Command being sent
    logic [1:0] nwords;  // Words of the command
    logic [1:0] widx;    // Words done
    logic [31:0] wbuf;   // Write data, low word first
    logic [31:0] rbuf;   // Read result, low word first
    logic cmd_sel;       // Bus: strobe carries a command
    logic wr_stb;        // Bus: write strobe
    logic rd_stb;        // Bus: read strobe
    logic [15:0] wdata;  // Bus: write word
    logic wr_pend;       // AHB write in data phase
    logic [7:0] addr;    // AHB address of the data phase
    logic [31:0] hrdata; // AHB read data
    logic hreadyout;     // AHB ready
  } host_state_s;

endpackage

// *** common/usb_dc_bus_if.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Parallel command/data bus between processor and device
// ----------------------------------------------------------------
interface usb_dc_bus_if (
  input logic clk_sys
);
  logic cmd_sel;       // High: the strobed word is a command code
  logic wr_stb;        // One-cycle write strobe
  logic rd_stb;        // One-cycle read strobe
  logic [15:0] wdata;  // Word written by the host
  logic [15:0] rdata;  // Word read, valid the cycle after rd_stb

  modport device (input cmd_sel, input wr_stb, input rd_stb, input wdata, output rdata);
  modport host (output cmd_sel, output wr_stb, output rd_stb, output wdata, input rdata);
endinterface

// *** rtl/event_latch.sv ***
`timescale 1ns/1ps
`include "usb_dc_defines.svh"

// ----------------------------------------------------------------
// Gated, rising-edge event capture with sticky status
// ----------------------------------------------------------------
module event_latch (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [31:0] src,
  input wire logic [31:0] en,
  input wire logic [31:0] clr,
  output logic [31:0] status
);
  usb_dc_pkg::evt_state_s s; // Registered state
  usb_dc_pkg::evt_state_s n; // Next state

  // Only a fresh rising edge seen while enabled is captured; a level that
  // was already high when the enable went up is never taken
  always_comb begin
    n = s;
    n.prev = src;
    n.status = (s.status & ~clr) | (src & ~s.prev & en); // Set wins over clear
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign status = s.status;
endmodule // event_latch

// *** rtl/usb_host_end.sv ***
`timescale 1ns/1ps
`include "usb_dc_defines.svh"

// ----------------------------------------------------------------
// Host end: AHB-Lite registers drive command sequences on the bus
// ----------------------------------------------------------------
module usb_host_end (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  usb_dc_bus_if.host bus
);
  usb_dc_pkg::host_state_s s; // Registered state
  usb_dc_pkg::host_state_s n; // Next state
  logic addr_ok;              // Valid address phase this cycle
  logic busy;                 // Sequence in progress

  assign addr_ok = hsel && htrans[1] && hready;
  assign busy = (s.st != usb_dc_pkg::H_IDLE);

  // Sequencer plus register slave; hsize is not checked, only words are
  // expected, so a narrow write simply lands as a word
  always_comb begin
    n = s;
    n.hreadyout = 1'b1;
    n.cmd_sel = 1'b0;
    n.wr_stb = 1'b0;
    n.rd_stb = 1'b0;

    // Address phase: remember writes, preload read data
    n.wr_pend = addr_ok && hwrite;
    n.addr = haddr[7:0];
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `H_CTRL: n.hrdata = {24'h000000, s.cmd};
        `H_WDATA: n.hrdata = s.wbuf;
        `H_RDATA: n.hrdata = s.rbuf;
        `H_STAT: n.hrdata = {31'h0, busy};
        default: n.hrdata = '0;            // Unmapped reads zero
      endcase
    end

    // Data phase of a write; a start while busy is ignored
    if (s.wr_pend) begin
      if (s.addr == `H_WDATA && !busy) begin
        n.wbuf = hwdata;
      end else if (s.addr == `H_CTRL && !busy) begin
        n.cmd = hwdata[7:0];
        n.nwords = usb_dc_pkg::cmd_words(hwdata[7:0]);
        n.widx = 2'd0;
        n.cmd_sel = 1'b1;
        n.wr_stb = 1'b1;
        n.wdata = {8'h00, hwdata[7:0]};
        n.st = usb_dc_pkg::H_CMD;
      end
    end

    case (s.st)
      usb_dc_pkg::H_IDLE: begin
        n.st = n.st;                       // Wait for a start
      end
      usb_dc_pkg::H_CMD, usb_dc_pkg::H_DATA: begin
        // Command or word strobe is on the bus now
        if (s.st == usb_dc_pkg::H_DATA && !s.cmd[0]) begin
          n.widx = s.widx + 2'd1;          // Write word accepted
        end
        if (s.st == usb_dc_pkg::H_DATA && s.cmd[0]) begin
          n.st = usb_dc_pkg::H_RCAP;       // Device answers next cycle
        end else if (n.widx >= s.nwords) begin
          n.st = usb_dc_pkg::H_IDLE;
        end else begin
          n.st = usb_dc_pkg::H_DATA;
          n.wr_stb = !s.cmd[0];
          n.rd_stb = s.cmd[0];
          n.wdata = (n.widx == 2'd0) ? s.wbuf[15:0] : s.wbuf[31:16];
        end
      end
      usb_dc_pkg::H_RCAP: begin
        // Low word first, then high word
        if (s.widx == 2'd0) begin
          n.rbuf = {16'h0000, bus.rdata};
        end else begin
          n.rbuf[31:16] = bus.rdata;
        end
        n.widx = s.widx + 2'd1;
        if (n.widx >= s.nwords) begin
          n.st = usb_dc_pkg::H_IDLE;
        end else begin
          n.st = usb_dc_pkg::H_DATA;
          n.rd_stb = 1'b1;
        end
      end
      default: begin
        n.st = usb_dc_pkg::H_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign bus.cmd_sel = s.cmd_sel;
  assign bus.wr_stb = s.wr_stb;
  assign bus.rd_stb = s.rd_stb;
  assign bus.wdata = s.wdata;
endmodule // usb_host_end

// *** dv/usb_dc_bus_properties.sv ***
`timescale 1ns/1ps
`include "usb_dc_defines.svh"

// ------
// Bus protocol checks between host end and device end
// ------
module usb_dc_bus_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cmd_sel,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // A command strobe carrying the given code
  sequence s_cmd(logic [7:0] code);
    wr_stb && cmd_sel && (wdata[7:0] == code);
  endsequence
  // One data word written
  sequence s_word_wr;
    wr_stb && !cmd_sel && !rd_stb;
  endsequence
  // One data word read
  sequence s_word_rd;
    rd_stb && !wr_stb;
  endsequence

  a_ie_wr_words: assert property (s_cmd(`CMD_IE_WR) |=> s_word_wr ##1 s_word_wr ##1 !wr_stb)
    else $error("enable write not followed by exactly two words");
  a_cfg_wr_word: assert property (s_cmd(`CMD_DCFG_WR) |=> s_word_wr ##1 !wr_stb)
    else $error("configuration write not followed by exactly one word");
  a_ie_rd_words: assert property (s_cmd(`CMD_IE_RD) |=> s_word_rd ##1 !rd_stb ##1 s_word_rd ##1 !rd_stb)
    else $error("enable read not followed by exactly two words");
  a_cfg_rd_word: assert property (s_cmd(`CMD_DCFG_RD) |=> s_word_rd ##1 !rd_stb ##1 !rd_stb)
    else $error("configuration read not followed by exactly one word");
  a_cfg_rsvd_zero: assert property (s_cmd(`CMD_DCFG_RD) ##2 1'b1 |-> (rdata & 16'h3f04) == 16'h0000)
    else $error("configuration reserved bits read nonzero");
  a_ie_rsvd_zero: assert property (s_cmd(`CMD_IE_RD) ##2 1'b1 |-> !rdata[7] ##2 rdata[15:8] == 8'h00)
    else $error("enable reserved bits read nonzero");
  a_rdata_holds: assert property (!$past(rd_stb) |-> $stable(rdata))
    else $error("read word changed without a read strobe");
  a_strobe_excl: assert property (wr_stb |-> !rd_stb)
    else $error("read and write strobes together");
  a_rd_pulse: assert property (rd_stb |=> !rd_stb)
    else $error("read strobe longer than one cycle");
endmodule // usb_dc_bus_properties

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`include "usb_dc_defines.svh"

module tb_top;
  // ------
  // Stimulus, model and bookkeeping
  // ------
  logic clk_sys = 1'b0; // 125 MHz
  logic sys_rst = 1'b1; // Synchronous, high
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] src = 32'h0; // Event levels laid out as status bits
  logic dma_byte_stb = 1'b0;
  logic out_short_rx = 1'b0;
  logic hreadyout, hresp, irq, dma_run, transfer_end_condition;
  logic [31:0] hrdata, r, m;
  logic [3:0] dma_endpoint_select;
  logic [1:0] dma_burst_length;
  int ie_m, cfg_m; // Model of the two registers
  int evq[$] = '{0, 1, 2, 4, 5, 6}; // Event bits under test
  int seed = 32'h3cca155e;
  int eot_n = 0; // End pulses seen
  int err_count = 0;
  int n_checks = 0;

  usb_dc_bus_if i_usb_dc_bus_if (.clk_sys(clk_sys));
  usb_device_end i_usb_device_end (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus(i_usb_dc_bus_if), .ep_evt(src[23:8]), .short_pkt_evt(src[6]),
    .pseudo_sof_evt(src[5]), .sof_evt(src[4]), .suspend_evt(src[2]),
    .resume_evt(src[1]), .usb_bus_reset(src[0]), .dma_byte_stb(dma_byte_stb),
    .out_short_rx(out_short_rx), .irq(irq), .dma_run(dma_run),
    .dma_endpoint_select(dma_endpoint_select), .dma_burst_length(dma_burst_length),
    .transfer_end_condition(transfer_end_condition));
  // Single slave: its ready is the bus ready
  usb_host_end i_usb_host_end (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .bus(i_usb_dc_bus_if));
  usb_dc_bus_properties i_usb_dc_bus_properties (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cmd_sel(i_usb_dc_bus_if.cmd_sel), .wr_stb(i_usb_dc_bus_if.wr_stb),
    .rd_stb(i_usb_dc_bus_if.rd_stb), .wdata(i_usb_dc_bus_if.wdata),
    .rdata(i_usb_dc_bus_if.rdata));

  // Clock generator
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // Count end-of-transfer pulses; one per cycle high
  always @(posedge clk_sys) begin
    if (transfer_end_condition === 1'b1) eot_n++;
  end

  // ------
  // Tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // One single AHB transfer; waits on ready, never on a fixed count
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Full command sequence: data, code, poll busy, fetch result
  task automatic cmd(input logic [7:0] c, input logic [31:0] d, output logic [31:0] q);
    ahb(1'b1, `H_WDATA, d, q);
    ahb(1'b1, `H_CTRL, {24'h0, c}, q);
    q = 32'h1;
    while (q[0] === 1'b1) ahb(1'b0, `H_STAT, 32'h0, q);
    ahb(1'b0, `H_RDATA, 32'h0, q);
  endtask

  task automatic final_report;
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog: far beyond the roughly 1500 cycles the sequence needs
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    final_report();
  end

  // ------
  // Main sequence
  // ------
  initial begin
    for (int i = 8; i < 24; i++) evq.push_back(i);
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    ahb(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
    // Random enables; software keeps the top byte zero
    repeat (4) begin
      ie_m = $random(seed) & 32'h00ff_ffff;
      cmd(`CMD_IE_WR, ie_m, r);
      cmd(`CMD_IE_RD, 32'h0, r);
      chk(r, ie_m & `IE_MASK);
    end
    // Every burst length, random endpoint and modes, run held off
    for (int b = 0; b < 4; b++) begin
      cfg_m = ($random(seed) & 32'hc0f0) | b;
      cmd(`CMD_DCFG_WR, cfg_m, r);
      cmd(`CMD_DCFG_RD, 32'h0, r);
      chk({16'h0, r[15:0]}, cfg_m);
      chk({30'h0, dma_burst_length}, b);
      chk({28'h0, dma_endpoint_select}, (cfg_m >> 4) & 15);
    end
    // Bus reset stops DMA only
    cfg_m = ($random(seed) & 32'h00f3) | 32'h8;
    cmd(`CMD_DCFG_WR, cfg_m, r);
    chk({31'h0, dma_run}, 32'h1);
    src[0] <= 1'b1;
    @(posedge clk_sys);
    src[0] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({31'h0, dma_run}, 32'h0);
    cmd(`CMD_IE_RD, 32'h0, r);
    chk(r, ie_m & `IE_MASK);
    cmd(`CMD_DCFG_RD, 32'h0, r);
    chk({16'h0, r[15:0]}, cfg_m & 32'hfff7);
    // Count of three; second run proves the reload
    cmd(`CMD_DCNT_WR, 32'h3, r);
    repeat (2) begin
      cmd(`CMD_DCFG_WR, 32'h8008, r);
      for (int j = 0; j < 3; j++) begin
        if (j == 2) chk({31'h0, dma_run}, 32'h1);
        dma_byte_stb <= 1'b1;
        @(posedge clk_sys);
        dma_byte_stb <= 1'b0;
        @(posedge clk_sys);
      end
      repeat (3) @(posedge clk_sys);
      chk({31'h0, dma_run}, 32'h0);
    end
    chk(eot_n, 32'h2);
    // Writing run high starts DMA again
    cmd(`CMD_DCFG_WR, 32'h0008, r);
    chk({31'h0, dma_run}, 32'h1);
    // Fresh start reloads the remaining counter from the count of three
    cmd(`CMD_DCNT_RD, 32'h0, r);
    chk({16'h0, r[15:0]}, 32'h3);
    cmd(`CMD_DCFG_WR, 32'h0000, r);
    chk({31'h0, dma_run}, 32'h0);
    // Short packet ends the transfer; only the end event is enabled, so
    // the status read afterwards must return that bit alone
    cmd(`CMD_IE_WR, 32'h8, r);
    cmd(`CMD_STAT_RD, 32'h0, r);
    // Endpoint index 0 is control OUT, so short packet mode is allowed
    cmd(`CMD_DCFG_WR, 32'h4008, r);
    out_short_rx <= 1'b1;
    @(posedge clk_sys);
    out_short_rx <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, dma_run}, 32'h0);
    chk(eot_n, 32'h3);
    cmd(`CMD_STAT_RD, 32'h0, r);
    chk(r, 32'h8);
    // Gating per event: disabled, enabled mid-event, then captured
    cmd(`CMD_STAT_RD, 32'h0, r);
    foreach (evq[i]) begin
      m = 32'h1 << evq[i];
      cmd(`CMD_IE_WR, `IE_MASK & ~m, r);
      src[evq[i]] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      cmd(`CMD_IE_WR, m, r);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      src[evq[i]] <= 1'b0;
      @(posedge clk_sys);
      src[evq[i]] <= 1'b1;
      @(posedge clk_sys);
      src[evq[i]] <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      cmd(`CMD_STAT_RD, 32'h0, r);
      chk(r, m);
      chk({31'h0, irq}, 32'h0);
    end
    final_report();
  end
endmodule // tb_top
